// ==== rtl/tfs_slave.sv ====
// Two-wire slave front end with internal 2048-byte array.
// Serial clock and data are asynchronous pins sampled by clk_sys.
// Write path passes a two-entry buffer before reaching the array.
`timescale 1ns/1ns
`default_nettype none
module tfs_slave #(
  parameter logic [3:0] DEV_TYPE = tfs_pkg::DEV_TYPE_RESET,
  parameter int DEPTH = 2048
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect,
  output var tfs_pkg::tfs_wr_t wr_word,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic busy
);
  import tfs_pkg::*;

  logic [SYNC_STAGES-1:0] scl_sync;
  logic [SYNC_STAGES-1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= '1;
      sda_sync <= '1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[SYNC_STAGES-2:0], scl_in};
      sda_sync <= {sda_sync[SYNC_STAGES-2:0], sda_in};
      if (scl_sync[1] == scl_sync[2])
        scl_q <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_q <= sda_sync[2];
    end
  end

  logic scl_d;
  logic sda_d;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign start_det = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_det = scl_q & scl_d & ~sda_d & sda_q;

  tfs_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic in_ack;
  logic ack_ok;
  logic ack_drive;
  logic [ADDR_W-1:0] addr;
  logic [7:0] rd_byte;
  logic rd_drive;
  logic [DATA_W-1:0] mem [DEPTH];

  // Buffer: two entries so a stalled array port loses no byte
  tfs_wr_t buf_q [2];
  logic [1:0] buf_cnt;
  logic buf_rd;
  logic buf_wr_sel;
  logic push;
  logic pop;
  tfs_wr_t push_word;
  logic buf_ready;

  assign buf_ready = (buf_cnt != 2'd2);
  assign wr_valid = (buf_cnt != 2'd0);
  assign pop = wr_valid & wr_ready;
  assign wr_word = buf_q[buf_rd];
  assign busy = (state != TFS_IDLE);

  // Device-type field of a slave address byte
  function automatic logic type_match(input logic [7:0] b);
    type_match = (b[7:TYPE_LSB] == DEV_TYPE);
  endfunction : type_match

  // Page select field of a slave address byte
  function automatic logic [2:0] page_of(input logic [7:0] b);
    page_of = b[TYPE_LSB-1:PAGE_LSB];
  endfunction : page_of

  // Direction bit of a slave address byte
  function automatic logic is_read(input logic [7:0] b);
    is_read = b[DIR_BIT];
  endfunction : is_read

  logic [7:0] rx_byte;
  assign rx_byte = {shift[6:0], sda_q};

  // Serial events, each valid for one clk_sys cycle
  logic abort;
  logic active;
  logic bit_rise;
  logic byte_done;
  logic slot_open;
  logic slot_close;
  logic ack_rise;
  logic rd_shift;

  assign abort = start_det | stop_det;
  assign active = (state != TFS_IDLE) && !abort;

  // Data bit taken on the rising serial clock
  assign bit_rise = active && scl_rise && !in_ack;

  // Byte complete on the eighth rising edge
  assign byte_done = bit_rise && (bit_cnt == 4'd7);

  // Acknowledge slot begins on the fall after the eighth bit
  assign slot_open = active && scl_fall && in_ack && (bit_cnt == 4'd8);

  // Acknowledge slot ends on the fall after the ninth clock
  assign slot_close = active && scl_fall && in_ack && (bit_cnt == 4'd9);

  // Master answer sampled on the rise inside the slot
  assign ack_rise = active && scl_rise && in_ack && (bit_cnt == 4'd9);

  // Next read bit presented on each fall within a byte
  assign rd_shift = active && scl_fall && !in_ack && (state == TFS_RDDATA)
      && (bit_cnt != 4'd0);

  // What the byte just received asks of the device
  logic slave_hit;
  logic take_data;
  logic accept;

  assign slave_hit = (state == TFS_SLAVE) && type_match(rx_byte);
  assign take_data = (state == TFS_WRDATA) && !write_protect && buf_ready;
  assign accept = slave_hit || (state == TFS_WORD) || take_data;

  // Transaction state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= TFS_IDLE;
    end else if (start_det) begin
      state <= TFS_SLAVE;
    end else if (stop_det) begin
      state <= TFS_IDLE;
    end else if (active) begin
      case (state)
        TFS_SLAVE: begin
          if (byte_done && !type_match(rx_byte)) begin
            state <= TFS_IDLE;
          end else if (slot_close) begin
            state <= is_read(shift) ? TFS_RDDATA : TFS_WORD;
          end
        end
        TFS_WORD: begin
          if (byte_done) begin
            state <= TFS_WRDATA;
          end
        end
        TFS_WRDATA: begin
          if (slot_close && !ack_drive) begin
            state <= TFS_IDLE;
          end
        end
        TFS_RDDATA: begin
          if (ack_rise && sda_q) begin
            state <= TFS_IDLE;
          end
        end
        default: begin
          state <= TFS_IDLE;
        end
      endcase
    end
  end

  // Bit position: 0 to 7 data, 8 after the byte, 9 inside the slot
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= 4'h0;
    end else if (abort) begin
      bit_cnt <= 4'h0;
    end else if (bit_rise) begin
      bit_cnt <= bit_cnt + 4'd1;
    end else if (slot_open) begin
      bit_cnt <= 4'd9;
    end else if (slot_close) begin
      bit_cnt <= 4'h0;
    end
  end

  // Acknowledge phase flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_ack <= 1'b0;
    end else if (abort) begin
      in_ack <= 1'b0;
    end else if (byte_done) begin
      in_ack <= 1'b1;
    end else if (slot_close) begin
      in_ack <= 1'b0;
    end
  end

  // Receive shifter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift <= 8'h00;
    end else if (bit_rise) begin
      shift <= rx_byte;
    end
  end

  // Verdict on the byte, kept until the slot opens
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_ok <= 1'b0;
    end else if (byte_done) begin
      ack_ok <= accept;
    end
  end

  // Pull starts on the fall, never while the serial clock is high,
  // so the pull itself cannot look like a START to anyone on the bus
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_drive <= 1'b0;
    end else if (abort) begin
      ack_drive <= 1'b0;
    end else if (slot_open) begin
      ack_drive <= ack_ok;
    end else if (slot_close) begin
      ack_drive <= 1'b0;
    end
  end

  // Address latch
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addr <= ADDR_RESET;
    end else if (byte_done) begin
      case (state)
        TFS_SLAVE: begin
          if (slave_hit) begin
            addr <= {page_of(rx_byte), addr[7:0]};
          end
        end
        TFS_WORD: begin
          addr <= {addr[ADDR_W-1:8], rx_byte};
        end
        TFS_WRDATA: begin
          if (take_data) begin
            addr <= addr + 11'd1;
          end
        end
        TFS_RDDATA: begin
          addr <= addr + 11'd1;
        end
        default: begin
          addr <= addr;
        end
      endcase
    end
  end

  // Word handed to the buffer right after the eighth bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      push <= 1'b0;
    end else begin
      push <= byte_done && take_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      push_word <= '0;
    end else if (byte_done && take_data) begin
      push_word <= '{addr: addr, data: rx_byte};
    end
  end

  // Read shifter: loaded at the end of a slot, shifted on falls
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_byte <= 8'h00;
      rd_drive <= 1'b0;
    end else if (abort) begin
      rd_drive <= 1'b0;
    end else if (slot_open) begin
      rd_drive <= 1'b0;
    end else if (slot_close && (state == TFS_RDDATA
        || (state == TFS_SLAVE && ack_drive && is_read(shift)))) begin
      rd_byte <= mem[addr];
      rd_drive <= 1'b1;
    end else if (rd_shift) begin
      rd_byte <= {rd_byte[6:0], 1'b1};
    end
  end

  // Free slot: behind the head when one word waits, else the head
  assign buf_wr_sel = buf_rd ^ (buf_cnt == 2'd1);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[buf_wr_sel] <= push_word;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buf_rd <= 1'b0;
    end else if (pop) begin
      buf_rd <= ~buf_rd;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buf_cnt <= 2'd0;
    end else begin
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Internal array takes words as the buffer drains
  always_ff @(posedge clk_sys) begin
    if (pop) begin
      mem[wr_word.addr] <= wr_word.data;
    end
  end

  // Read bit stands from one fall to the next, through the high phase
  logic rd_bit_low;
  assign rd_bit_low = rd_drive && !rd_byte[7];

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive | rd_bit_low;
endmodule : tfs_slave
`default_nettype wire

// ==== rtl/tfs_pkg.sv ====
// Package for the two-wire memory slave front end: constants and carriers.
// Assumes a single system clock much faster than the serial clock.
//
// Overview of operation
// - Data rising while clock high is a STOP.
// - STOP aborts any read or write and returns to idle.
// - Data falling while clock high is a START.
// - START aborts the current operation and awaits a new slave address.
// - Data sampled while clock high; transmitter holds data steady then.
// - After eighth bit transmitter releases data; receiver pulls low to acknowledge.
// - Data left high in acknowledge slot is a no-acknowledge ending the operation.
// - First byte after START is slave address; bits 7-4 match device type.
// - Slave address bits 3-1 select page, top three address bits.
// - Slave address bit 0 high means read, low means write.
// - In write, next byte loads low eight bits of eleven-bit address.
// - Read takes no word address; latch page, keep stored low bits.
// - Address latch increments after each data byte, before acknowledge.
// - Address wraps from 7ff to 000 for reads and writes.
// - No limit on sequential bytes in one transaction; code refuses a data byte while the two-entry buffer is full.
// - Read drives eight bits then samples master acknowledge.
// - Write receives eight bits then drives acknowledge.
// - Every byte travels most significant bit first.
// - Array write commits after eighth bit; START or STOP earlier leaves memory.
// - Device never busy; address poll after write always acknowledged.
// - Write protect high blocks acknowledge and storage of data bytes.
// - Protected write attempt leaves address latch unchanged; code still loads page and word address, only refused data bytes leave it alone.
// - Sample on rising clock edges, change output on falling edges.

package tfs_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [3:0] DEV_TYPE_RESET = 4'h0; // Arbitrary neutral value
  localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
  localparam int SYNC_STAGES = 3;
  localparam int DIR_BIT = 0;
  localparam int PAGE_LSB = 1;
  localparam int TYPE_LSB = 4;

  typedef enum {TFS_IDLE, TFS_SLAVE, TFS_WORD, TFS_WRDATA, TFS_RDDATA} tfs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tfs_wr_t;
endpackage : tfs_pkg

// ==== tb/tfs_slave_properties.sv ====
// Port checker for tfs_slave.
// Assumes the bench drives the serial pins at clk_sys falling edges.
`timescale 1ns/1ns
`default_nettype none
module tfs_slave_properties (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire tfs_pkg::tfs_wr_t wr_word,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_pull_only; sda_oe |-> !sda_out; endproperty
  a_pull_only: assert property (p_pull_only) else $error("pin driven high");
  property p_stop_idle; scl_in && $rose(sda_in) |-> ##[1:8] !busy; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop ignored");
  property p_start_busy; scl_in && $fell(sda_in) |-> ##[1:8] busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start ignored");
  // Sync delay puts the change five edges after the fall
  property p_oe_on_low; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
  a_oe_on_low: assert property (p_oe_on_low) else $error("oe moved in high");
  property p_oe_stands; $rose(sda_oe) |-> sda_oe [*5]; endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("short drive");
  property p_idle_quiet; !busy |-> !sda_oe; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle drive");
  property p_wp_block; $rose(wr_valid) |-> !write_protect; endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected store");
  property p_buf_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_word); endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("word lost");
endmodule : tfs_slave_properties
bind tfs_slave tfs_slave_properties tfs_slave_properties_inst (.clk_sys, .reset_n,
  .scl_in, .sda_in, .sda_out, .sda_oe, .write_protect, .wr_word, .wr_valid,
  .wr_ready, .busy);
`default_nettype wire

// ==== tb/tfs_master.sv ====
// Bus master model: makes the 800 ns serial clock only within frames.
// Assumes the bench resolves the wired-AND data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module tfs_master (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  task automatic bit_io(input logic d, output logic q);
    scl = 1'b0;
    wt(3);
    sda_m = d;
    wt(3);
    scl = 1'b1;
    wt(1);
    q = sda;
    wt(1);
  endtask : bit_io
  // One for a start, zero for a stop
  task automatic cond(input logic first);
    scl = 1'b0;
    wt(3);
    sda_m = first;
    wt(3);
    scl = 1'b1;
    wt(4);
    sda_m = !first;
    wt(4);
  endtask : cond
  task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m_ack, ack);
  endtask : xfer
endmodule : tfs_master
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for tfs_slave with a bus master model.
// Assumes a 100 ns clk_sys and a device-type code set by parameter.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tfs_pkg::*;
  localparam logic [3:0] TYPE = 4'h6; // Arbitrary device-type code
  typedef struct packed {logic [2:0] pg; logic [7:0] lo; logic [7:0] d;} tfs_row_t;
  tfs_row_t rows [3] = '{'{3'h0, 8'h10, 8'ha5}, '{3'h3, 8'hff, 8'h3c}, '{3'h7, 8'hff, 8'h81}};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic write_protect = 1'b0;
  logic wr_ready = 1'b1;
  logic scl, sda_m, sda_out, sda_oe, wr_valid, busy, ack;
  logic [7:0] q;
  tfs_wr_t wr_word;
  int err_count = 0;
  int checks = 0;
  wire logic sda = sda_m & ~sda_oe;
  tfs_slave #(.DEV_TYPE(TYPE)) tfs_slave_inst (.clk_sys, .reset_n, .scl_in(scl),
    .sda_in(sda), .sda_out, .sda_oe, .write_protect, .wr_word, .wr_valid, .wr_ready, .busy);
  tfs_master tfs_master_inst (.clk_sys, .sda, .scl, .sda_m);
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic sb(input logic [7:0] d, input logic exp);
    tfs_master_inst.xfer(d, 1'b1, q, ack);
    chk(ack, exp);
  endtask : sb
  task automatic rb(input logic m_ack, input logic [7:0] exp);
    tfs_master_inst.xfer(8'hff, m_ack, q, ack);
    chk(q, exp);
  endtask : rb
  task automatic cmd(input logic [2:0] pg, input logic rw);
    tfs_master_inst.cond(1'b1);
    sb({TYPE, pg, rw}, 1'b0);
  endtask : cmd
  task automatic stop;
    tfs_master_inst.cond(1'b0);
  endtask : stop
  initial begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({busy, wr_valid, sda_oe}, 20'h0);
    foreach (rows[i]) begin
      cmd(rows[i].pg, 1'b0);
      sb(rows[i].lo, 1'b0);
      sb(rows[i].d, 1'b0);
      sb(~rows[i].d, 1'b0);
      stop();
      cmd(rows[i].pg, 1'b0);
      sb(rows[i].lo, 1'b0);
      cmd(rows[i].pg, 1'b1);
      rb(1'b0, rows[i].d);
      rb(1'b1, ~rows[i].d);
      stop();
      $display("row %0d done", i);
    end
    tfs_master_inst.cond(1'b1);
    sb({~TYPE, 4'h0}, 1'b1);
    stop();
    $display("type test done");
    write_protect = 1'b1;
    cmd(3'h0, 1'b0);
    sb(8'h10, 1'b0);
    sb(8'h00, 1'b1);
    stop();
    write_protect = 1'b0;
    cmd(3'h0, 1'b1);
    rb(1'b1, 8'ha5);
    stop();
    $display("protect test done");
    cmd(3'h0, 1'b0);
    sb(8'h11, 1'b0);
    repeat (4) tfs_master_inst.bit_io(1'b0, ack);
    cmd(3'h0, 1'b1);
    rb(1'b1, 8'h5a);
    stop();
    $display("abort test done");
    wr_ready = 1'b0;
    cmd(3'h0, 1'b0);
    sb(8'h20, 1'b0);
    sb(8'h11, 1'b0);
    sb(8'h22, 1'b0);
    sb(8'h33, 1'b1);
    chk({wr_valid, wr_word}, {1'b1, 11'h020, 8'h11});
    stop();
    wr_ready = 1'b1;
    cmd(3'h0, 1'b0);
    chk(wr_valid, 1'b0);
    sb(8'h20, 1'b0);
    cmd(3'h0, 1'b1);
    rb(1'b0, 8'h11);
    rb(1'b1, 8'h22);
    stop();
    $display("buffer test done");
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
endmodule : tb
`default_nettype wire
